// file: core/acrm_pkg.sv
// Constants of the accelerometer register bank
`default_nettype none
package acrm_pkg;
    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int SMP_W = 14;
    localparam int NUM_REGS = 50;
    localparam int NUM_AXES = 3;
    localparam int NUM_PINS = 2;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [5:0] DATA_STATUS = 6'h00;
    localparam logic [5:0] X_SAMPLE_HIGH = 6'h01;
    localparam logic [5:0] Z_SAMPLE_LOW = 6'h06;
    localparam logic [5:0] SYSTEM_MODE_STATUS = 6'h0B;
    localparam logic [5:0] INTERRUPT_SOURCE_STATUS = 6'h0C;
    localparam logic [5:0] DEVICE_IDENTITY = 6'h0D;
    localparam logic [5:0] RANGE_AND_OUTPUT_CONFIG = 6'h0E;
    localparam logic [5:0] ORIENTATION_STATUS = 6'h10;
    localparam logic [5:0] ORIENTATION_BACKFRONT_ZTILT = 6'h13;
    localparam logic [5:0] FALL_MOTION_SOURCE = 6'h16;
    localparam logic [5:0] JOLT_SOURCE = 6'h1E;
    localparam logic [5:0] TAP_SOURCE = 6'h22;
    localparam logic [5:0] TAP_THRESHOLD_X = 6'h23;
    localparam logic [5:0] TAP_THRESHOLD_Z = 6'h25;
    localparam logic [5:0] TAP_FIRST_TIME_LIMIT = 6'h26;
    localparam logic [5:0] CONTROL_RATE_ACTIVE = 6'h2A;
    localparam logic [5:0] CONTROL_WAKE_PIN_TYPE = 6'h2C;
    localparam logic [5:0] INTERRUPT_ENABLE_MAP = 6'h2D;
    localparam logic [5:0] INTERRUPT_PIN_ROUTING = 6'h2E;
    localparam logic [5:0] X_OFFSET_CORRECTION = 6'h2F;
    // ****************************************************************
    // Field positions and codes
    // ****************************************************************
    localparam int FAST_READ_BIT = 1;
    localparam int ACTIVE_BIT = 0;
    localparam int IRQ_POLARITY_BIT = 1;
    localparam int IRQ_OUTPUT_TYPE_BIT = 0;
    localparam int FS_MSB = 1;
    localparam logic [1:0] FS_SMALL = 2'h0;
    localparam logic [1:0] FS_MID = 2'h1;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic signed [15:0] SMP_MAX = 16'sh1FFF;
    localparam logic signed [15:0] SMP_MIN = -16'sh2000;
    // ****************************************************************
    // Writable bits per offset, zero where nothing is writable
    // ****************************************************************
    function automatic logic [7:0] acrm_wr_mask(input logic [5:0] a);
        case (a)
            6'h09, 6'h12, 6'h14, 6'h17, 6'h18, 6'h1F, 6'h20, 6'h21,
            6'h26, 6'h27, 6'h28, 6'h29, 6'h2A, 6'h2F, 6'h30,
            6'h31: return 8'hFF;
            6'h0A: return 8'h3C;
            6'h0E: return 8'h13;
            6'h0F: return 8'h33;
            6'h11: return 8'hC0;
            6'h13: return 8'hC7;
            6'h15: return 8'hF8;
            6'h1D: return 8'h1F;
            6'h23, 6'h24, 6'h25: return 8'h7F;
            6'h2B: return 8'hDF;
            6'h2C: return 8'hFB;
            6'h2D, 6'h2E: return 8'hFD;
            default: return 8'h00;
        endcase
    endfunction
endpackage
`default_nettype wire

// file: core/acrm_regbank.sv
// Register bank of a three-axis accelerometer with interrupt pin drive
// ********************************************************************
// ********************************************************************
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module acrm_regbank #(
    parameter logic [7:0] IDENTITY = 8'h5C // Arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [acrm_pkg::ADDR_W-1:0] i_addr,
    input wire logic [acrm_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [acrm_pkg::DATA_W-1:0] o_rd_data,
    input wire logic i_sample_valid,
    input wire logic [acrm_pkg::SMP_W-1:0] i_x_raw,
    input wire logic [acrm_pkg::SMP_W-1:0] i_y_raw,
    input wire logic [acrm_pkg::SMP_W-1:0] i_z_raw,
    input wire logic [7:0] i_event_level,
    input wire logic [7:0] i_orient_status,
    input wire logic [7:0] i_fall_source,
    input wire logic [7:0] i_jolt_source,
    input wire logic [7:0] i_tap_source,
    output logic o_irq_pin_first_o,
    output logic o_irq_pin_first_oe_n,
    output logic o_irq_pin_second_o,
    output logic o_irq_pin_second_oe_n
);
    import acrm_pkg::*;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic [7:0] rw_ff [0:NUM_REGS-1];
    wire logic [7:0] cur_mask = acrm_wr_mask(i_addr);
    wire logic is_rw = |cur_mask;
    wire logic [7:0] cfg_data = rw_ff[RANGE_AND_OUTPUT_CONFIG];
    wire logic [7:0] ctrl_rate = rw_ff[CONTROL_RATE_ACTIVE];
    wire logic [7:0] ctrl_pin = rw_ff[CONTROL_WAKE_PIN_TYPE];
    wire logic [7:0] irq_en = rw_ff[INTERRUPT_ENABLE_MAP];
    wire logic [7:0] irq_route = rw_ff[INTERRUPT_PIN_ROUTING];
    wire logic [1:0] fs_sel = cfg_data[FS_MSB:0];
    wire logic fast_read = ctrl_rate[FAST_READ_BIT];
    wire logic irq_polarity_select = ctrl_pin[IRQ_POLARITY_BIT];
    wire logic irq_output_type = ctrl_pin[IRQ_OUTPUT_TYPE_BIT];

    // ****************************************************************
    // Writable register storage
    // ****************************************************************
    genvar gr;
    generate
        for (gr = 0; gr < NUM_REGS; gr++) begin : g_reg
            wire logic [7:0] msk = acrm_wr_mask(6'(gr));
            wire logic hit = i_wr && (i_addr == 6'(gr));
            wire logic [7:0] nxt_reg = (i_wr_data & msk);
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    rw_ff[gr] <= RESET_VAL;
                end else if (hit) begin
                    rw_ff[gr] <= nxt_reg;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Axis samples with offset correction and data-ready flags
    // ****************************************************************
    logic [SMP_W-1:0] smp_ff [0:NUM_AXES-1];
    logic [NUM_AXES-1:0] dr_ff;
    logic [NUM_AXES-1:0] ow_ff;
    wire logic [SMP_W-1:0] raw_w [0:NUM_AXES-1];
    assign raw_w[0] = i_x_raw;
    assign raw_w[1] = i_y_raw;
    assign raw_w[2] = i_z_raw;

    genvar ga;
    generate
        for (ga = 0; ga < NUM_AXES; ga++) begin : g_axis
            wire logic [7:0] off = rw_ff[int'(X_OFFSET_CORRECTION) + ga];
            wire logic signed [15:0] off_ext = 16'(signed'(off));
            wire logic signed [15:0] raw_ext = 16'(signed'(raw_w[ga]));
            // 2 mg per count is 8, 4 or 2 sample counts by range
            wire logic signed [15:0] off_sc =
                (fs_sel == FS_SMALL) ? (off_ext <<< 3) :
                (fs_sel == FS_MID) ? (off_ext <<< 2) : (off_ext <<< 1);
            wire logic signed [15:0] sum = raw_ext + off_sc;
            wire logic [SMP_W-1:0] nxt_smp =
                (sum > SMP_MAX) ? SMP_MAX[SMP_W-1:0] :
                (sum < SMP_MIN) ? SMP_MIN[SMP_W-1:0] : sum[SMP_W-1:0];
            wire logic hi_rd = i_rd &&
                (i_addr == 6'(int'(X_SAMPLE_HIGH) + 2 * ga));
            // A new sample wins over the clearing read
            wire logic nxt_dr = i_sample_valid | (dr_ff[ga] & ~hi_rd);
            wire logic nxt_ow = (i_sample_valid & dr_ff[ga]) |
                (ow_ff[ga] & ~hi_rd);
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    smp_ff[ga] <= '0;
                    dr_ff[ga] <= 1'b0;
                    ow_ff[ga] <= 1'b0;
                end else begin
                    if (i_sample_valid) begin
                        smp_ff[ga] <= nxt_smp;
                    end
                    dr_ff[ga] <= nxt_dr;
                    ow_ff[ga] <= nxt_ow;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Status views
    // ****************************************************************
    wire logic [7:0] data_status = {|ow_ff, ow_ff[2], ow_ff[1], ow_ff[0],
                                    |dr_ff, dr_ff[2], dr_ff[1], dr_ff[0]};
    wire logic [7:0] src_status = {i_event_level[7:2], 1'b0, |dr_ff};
    wire logic [7:0] sys_mode = {7'h00, ctrl_rate[ACTIVE_BIT]};
    wire logic [5:0] smp_off = i_addr - X_SAMPLE_HIGH;
    wire logic is_smp = (i_addr >= X_SAMPLE_HIGH) &&
                        (i_addr <= Z_SAMPLE_LOW);
    wire logic [SMP_W-1:0] sel_smp = smp_ff[smp_off[2:1]];
    // Fast read drops the low bytes so only the 8-bit value remains
    wire logic [7:0] smp_byte = !smp_off[0] ? sel_smp[13:6] :
        fast_read ? 8'h00 : {sel_smp[5:0], 2'b00};

    // ****************************************************************
    // Read selection
    // ****************************************************************
    function automatic logic [7:0] ro_sel(input logic [5:0] a);
        case (a)
            DATA_STATUS: return data_status;
            SYSTEM_MODE_STATUS: return sys_mode;
            INTERRUPT_SOURCE_STATUS: return src_status;
            DEVICE_IDENTITY: return IDENTITY;
            ORIENTATION_STATUS: return i_orient_status;
            FALL_MOTION_SOURCE: return i_fall_source;
            JOLT_SOURCE: return i_jolt_source;
            TAP_SOURCE: return i_tap_source;
            default: return 8'h00;
        endcase
    endfunction

    wire logic [7:0] rd_val = is_smp ? smp_byte :
        is_rw ? rw_ff[i_addr] : ro_sel(i_addr);
    wire logic [7:0] nxt_rd_data = i_rd ? rd_val : 8'h00;

    logic [7:0] rd_data_ff;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end
    assign o_rd_data = rd_data_ff;

    // ****************************************************************
    // Interrupt routing and pin drive
    // ****************************************************************
    wire logic [7:0] live = src_status & irq_en;
    wire logic [NUM_PINS-1:0] pin_act;
    assign pin_act[0] = |(live & irq_route);
    assign pin_act[1] = |(live & ~irq_route);
    logic [NUM_PINS-1:0] pin_o_ff;
    logic [NUM_PINS-1:0] pin_oe_n_ff;

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
            wire logic lvl = pin_act[gp] ^ ~irq_polarity_select;
            // Open-drain pulls low only; a high level is released
            wire logic nxt_o = irq_output_type ? 1'b0 : lvl;
            wire logic nxt_oe_n = irq_output_type ? lvl : 1'b0;
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    pin_o_ff[gp] <= 1'b1;
                    pin_oe_n_ff[gp] <= 1'b0;
                end else begin
                    pin_o_ff[gp] <= nxt_o;
                    pin_oe_n_ff[gp] <= nxt_oe_n;
                end
            end
        end
    endgenerate
    assign o_irq_pin_first_o = pin_o_ff[0];
    assign o_irq_pin_first_oe_n = pin_oe_n_ff[0];
    assign o_irq_pin_second_o = pin_o_ff[1];
    assign o_irq_pin_second_oe_n = pin_oe_n_ff[1];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    rd_next_cycle_a: assert property (
        i_rd |=> (o_rd_data == $past(rd_val)) ##1 (!$past(i_rd) ||
        o_rd_data == $past(rd_val)))
        else $error("Read data not shown one cycle later");
    tap_limit_rw_a: assert property (
        (i_wr && i_addr == TAP_FIRST_TIME_LIMIT) ##1
        (i_rd && i_addr == TAP_FIRST_TIME_LIMIT && !i_wr)
        |=> o_rd_data == $past(i_wr_data, 2))
        else $error("Tap time limit did not read back");
    tap_level_bit7_a: assert property (
        (i_rd && i_addr >= TAP_THRESHOLD_X && i_addr <= TAP_THRESHOLD_Z)
        |=> !o_rd_data[7])
        else $error("Tap threshold bit 7 not zero");
    backfront_gap_a: assert property (
        (i_rd && i_addr == ORIENTATION_BACKFRONT_ZTILT)
        |=> o_rd_data[5:3] == 3'h0)
        else $error("Unused back/front bits not zero");
    low_byte_pad_a: assert property (
        (i_rd && is_smp && smp_off[0]) |=> o_rd_data[1:0] == 2'h0)
        else $error("Low byte padding not zero");
    sample_fmt_a: assert property (
        (i_sample_valid && rw_ff[X_OFFSET_CORRECTION] == 8'h00)
        ##1 (i_rd && i_addr == X_SAMPLE_HIGH)
        |=> o_rd_data == $past(i_x_raw[13:6], 2))
        else $error("High byte does not carry sample bits 13:6");
    offset_scale_a: assert property (
        (i_sample_valid && i_x_raw == 14'h0000 && fs_sel == FS_SMALL
        && rw_ff[X_OFFSET_CORRECTION] == 8'h01) |=> smp_ff[0] == 14'h0008)
        else $error("Offset of one count not worth 2 mg");
    route_first_a: assert property (
        (pin_act[0] && !irq_polarity_select && !irq_output_type)
        |=> !o_irq_pin_first_o && !o_irq_pin_first_oe_n)
        else $error("First pin not driven low for routed source");
    route_second_a: assert property (
        (pin_act[1] && irq_polarity_select && !irq_output_type)
        |=> o_irq_pin_second_o)
        else $error("Second pin not high under high polarity");
    open_drain_a: assert property (
        (irq_output_type && !pin_act[0] && !irq_polarity_select)
        |=> o_irq_pin_first_oe_n && !o_irq_pin_first_o)
        else $error("Open-drain pin not released when idle");

    rd_idle_zero_a: assert property (
        !i_rd |=> o_rd_data == 8'h00)
        else $error("Read data not zero outside read cycle");
    ready_set_a: assert property (
        i_sample_valid |=> dr_ff == 3'h7)
        else $error("Data-ready flags not set by new sample");
    ready_clear_a: assert property (
        (i_rd && i_addr == X_SAMPLE_HIGH && !i_sample_valid)
        |=> !dr_ff[0] && !ow_ff[0])
        else $error("Reading high byte did not clear flags");
    overwrite_set_a: assert property (
        (i_sample_valid && dr_ff[1]) |=> ow_ff[1])
        else $error("Overwrite flag not set on stale sample");
    fast_low_zero_a: assert property (
        (i_rd && is_smp && smp_off[0] && fast_read)
        |=> o_rd_data == 8'h00)
        else $error("Low byte not zero in fast read");
    identity_rd_a: assert property (
        (i_rd && i_addr == DEVICE_IDENTITY) |=> o_rd_data == IDENTITY)
        else $error("Identity register reads wrong value");

    sample_read_c: cover property (
        i_sample_valid ##1 (i_rd && i_addr == X_SAMPLE_HIGH));
    first_pin_c: cover property (pin_act[0] ##1 !o_irq_pin_first_o);
    od_release_c: cover property (irq_output_type ##1 o_irq_pin_first_oe_n);
    fast_read_c: cover property (fast_read && i_rd && is_smp);
endmodule
`default_nettype wire

// file: dv/acrm_host_model.sv
// Host side model: register bus master and pulled-up interrupt lines
`timescale 1ns/10ps
`default_nettype none
module acrm_host_model (
    input wire logic i_clk,
    output logic [acrm_pkg::ADDR_W-1:0] o_addr,
    output logic [acrm_pkg::DATA_W-1:0] o_wr_data,
    output logic o_wr,
    output logic o_rd,
    input wire logic [acrm_pkg::DATA_W-1:0] i_rd_data,
    input wire logic i_first_o,
    input wire logic i_first_oe_n,
    input wire logic i_second_o,
    input wire logic i_second_oe_n,
    output logic o_first_line,
    output logic o_second_line
);
    import acrm_pkg::*;
    // ****************************************************************
    // Lines carry a pull-up, so a released pin reads high
    // ****************************************************************
    assign o_first_line = i_first_oe_n ? 1'b1 : i_first_o;
    assign o_second_line = i_second_oe_n ? 1'b1 : i_second_o;
    initial begin
        o_addr = '0;
        o_wr_data = '0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // ****************************************************************
    // Bus cycles; idle address and data show the inverse of the last
    // ****************************************************************
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wr_data <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wr_data <= ~d;
    endtask
    // Write then read with no gap between the two strobes
    task automatic wr_rd(input logic [5:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wr_data <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b1;
        o_wr_data <= ~d;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        q = i_rd_data;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rd_data;
    endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the accelerometer register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import acrm_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic wr, rd, f_o, f_oe_n, s_o, s_oe_n, line1, line2;
    logic smp_v = 1'b0;
    logic [SMP_W-1:0] xr = '0, yr = '0, zr = '0;
    logic [7:0] ev = 8'h00, orient = 8'h81, fall = 8'hA2;
    logic [7:0] jolt = 8'h44, tap = 8'hC8;
    int miscompares = 0;
    int check_count = 0;
    acrm_regbank #(.IDENTITY(ID_VAL)) u_acrm_regbank (.i_clk(clk),
        .i_reset_n(rst_n), .i_addr(addr), .i_wr_data(wdata), .i_wr(wr),
        .i_rd(rd), .o_rd_data(rdata), .i_sample_valid(smp_v),
        .i_x_raw(xr), .i_y_raw(yr), .i_z_raw(zr), .i_event_level(ev),
        .i_orient_status(orient), .i_fall_source(fall),
        .i_jolt_source(jolt), .i_tap_source(tap),
        .o_irq_pin_first_o(f_o), .o_irq_pin_first_oe_n(f_oe_n),
        .o_irq_pin_second_o(s_o), .o_irq_pin_second_oe_n(s_oe_n));
    acrm_host_model u_acrm_host_model (.i_clk(clk), .o_addr(addr),
        .o_wr_data(wdata), .o_wr(wr), .o_rd(rd), .i_rd_data(rdata),
        .i_first_o(f_o), .i_first_oe_n(f_oe_n), .i_second_o(s_o),
        .i_second_oe_n(s_oe_n), .o_first_line(line1),
        .o_second_line(line2));
    initial begin
        forever #20 clk = ~clk;
    end
    // ****************************************************************
    // Shared helpers
    // ****************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [5:0] a, input logic [7:0] d);
        u_acrm_host_model.wr(a, d);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_acrm_host_model.rd(a, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    task automatic samp(input logic [13:0] x, y, z);
        @(posedge clk);
        smp_v <= 1'b1;
        xr <= x;
        yr <= y;
        zr <= z;
        @(posedge clk);
        smp_v <= 1'b0;
        xr <= ~x;
        yr <= ~y;
        zr <= ~z;
    endtask
    function automatic logic [13:0] sat(logic [13:0] r, logic [7:0] o,
                                        int k);
        int s;
        s = $signed(r) + $signed(o) * k;
        if (s > 8191) s = 8191;
        if (s < -8192) s = -8192;
        return s[13:0];
    endfunction
    task automatic samp_rd(input logic [13:0] x);
        logic [7:0] d;
        @(posedge clk);
        smp_v <= 1'b1;
        xr <= x;
        fork
            begin
                @(posedge clk);
                smp_v <= 1'b0;
                xr <= ~x;
            end
            u_acrm_host_model.rd(X_SAMPLE_HIGH, d);
        join
        chk({8'h00, d}, {8'h00, x[13:6]});
    endtask
    task automatic axis_chk(input int i, input logic [13:0] e, input bit f);
        rd_chk(6'(1 + 2 * i), e[13:6]);
        rd_chk(6'(2 + 2 * i), f ? 8'h00 : {e[5:0], 2'b00});
    endtask
    task automatic pin_chk(input logic [5:0] e);
        repeat (2) @(posedge clk);
        #1;
        chk({10'h000, line1, line2, f_o, f_oe_n, s_o, s_oe_n}, {10'h000, e});
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        logic [7:0] q;
        rd_chk(TAP_FIRST_TIME_LIMIT, 8'h00);
        rd_chk(DEVICE_IDENTITY, ID_VAL);
        w(TAP_FIRST_TIME_LIMIT, 8'hA5);
        rd_chk(TAP_FIRST_TIME_LIMIT, 8'hA5);
        w(TAP_FIRST_TIME_LIMIT, 8'h5A);
        rd_chk(TAP_FIRST_TIME_LIMIT, 8'h5A);
        u_acrm_host_model.wr_rd(TAP_FIRST_TIME_LIMIT, 8'h3B, q);
        chk({8'h00, q}, 16'h003B);
        for (int a = TAP_THRESHOLD_X; a <= TAP_THRESHOLD_Z; a++) begin
            w(6'(a), {1'b1, 7'(a * 3)});
        end
        for (int a = TAP_THRESHOLD_X; a <= TAP_THRESHOLD_Z; a++) begin
            rd_chk(6'(a), {1'b0, 7'(a * 3)});
        end
        w(ORIENTATION_BACKFRONT_ZTILT, 8'hFF);
        rd_chk(ORIENTATION_BACKFRONT_ZTILT, 8'hC7);
        w(ORIENTATION_BACKFRONT_ZTILT, 8'h79);
        rd_chk(ORIENTATION_BACKFRONT_ZTILT, 8'h41);
        w(DEVICE_IDENTITY, 8'hFF);
        rd_chk(DEVICE_IDENTITY, ID_VAL);
        w(6'h07, 8'hFF);
        rd_chk(6'h07, 8'h00);
        rd_chk(ORIENTATION_STATUS, orient);
        rd_chk(TAP_SOURCE, tap);
        rd_chk(FALL_MOTION_SOURCE, fall);
        rd_chk(JOLT_SOURCE, jolt);
    endtask
    task automatic t_samp();
        samp(14'h2ABC, 14'h1555, 14'h2000);
        rd_chk(DATA_STATUS, 8'h0F);
        axis_chk(0, 14'h2ABC, 0);
        axis_chk(1, 14'h1555, 0);
        axis_chk(2, 14'h2000, 0);
        samp_rd(14'h1234);
        w(CONTROL_RATE_ACTIVE, 8'h03);
        rd_chk(SYSTEM_MODE_STATUS, 8'h01);
        samp(14'h1FFF, 14'h0001, 14'h3FFF);
        rd_chk(DATA_STATUS, 8'hEF);
        axis_chk(0, 14'h1FFF, 1);
        axis_chk(2, 14'h3FFF, 1);
        w(CONTROL_RATE_ACTIVE, 8'h00);
    endtask
    task automatic t_offset();
        int k;
        w(X_OFFSET_CORRECTION, 8'hFB);
        w(6'h30, 8'h7F);
        w(6'h31, 8'h80);
        for (int fs = 0; fs < 4; fs++) begin
            k = (fs == 3) ? 2 : (8 >> fs);
            w(RANGE_AND_OUTPUT_CONFIG, 8'(fs));
            samp(14'h0100, 14'h1FFE, 14'h2003);
            axis_chk(0, sat(14'h0100, 8'hFB, k), 0);
            axis_chk(1, sat(14'h1FFE, 8'h7F, k), 0);
            axis_chk(2, sat(14'h2003, 8'h80, k), 0);
        end
        w(RANGE_AND_OUTPUT_CONFIG, 8'h00);
        w(X_OFFSET_CORRECTION, 8'h01);
        samp(14'h0000, 14'h0000, 14'h0000);
        axis_chk(0, 14'h0008, 0);
    endtask
    task automatic t_irq();
        pin_chk(6'b11_1010);
        @(posedge clk);
        ev <= 8'h08;
        w(INTERRUPT_ENABLE_MAP, 8'h08);
        pin_chk(6'b10_1000);
        w(INTERRUPT_PIN_ROUTING, 8'h08);
        pin_chk(6'b01_0010);
        w(CONTROL_WAKE_PIN_TYPE, 8'h02);
        pin_chk(6'b10_1000);
        w(CONTROL_WAKE_PIN_TYPE, 8'h01);
        pin_chk(6'b01_0001);
        w(CONTROL_WAKE_PIN_TYPE, 8'h03);
        pin_chk(6'b10_0100);
        @(posedge clk);
        ev <= 8'h04;
        pin_chk(6'b00_0000);
        w(CONTROL_WAKE_PIN_TYPE, 8'h00);
        w(INTERRUPT_ENABLE_MAP, 8'h01);
        w(INTERRUPT_PIN_ROUTING, 8'h00);
        @(posedge clk);
        ev <= 8'h00;
        samp(14'h0010, 14'h0020, 14'h0030);
        pin_chk(6'b10_1000);
        rd_chk(INTERRUPT_SOURCE_STATUS, 8'h01);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_samp();
        t_offset();
        t_irq();
        tally_and_finish();
    end
endmodule
`default_nettype wire
